// [include/tx_in_pkg.sv]
package tx_in_pkg;
  // character and buffer geometry
  localparam int CHAR_W = 10;
  localparam int BUF_ADDR_W = 3;
  // configuration latch bit positions
  localparam int CFG_SEL = 0;
  localparam int CFG_RECENTER_N = 1;
  localparam int CFG_BIST_N = 2;
  localparam int CFG_OE1 = 3;
  localparam int CFG_OE2 = 4;
  localparam int CFG_HALF = 5;
  localparam int CFG_W = 6;
  // reset values
  localparam logic [CHAR_W-1:0] CHAR_RST = 10'h000;
  // outputs enabled at reset so the flag does not blip while config syncs
  localparam logic [CFG_W-1:0] CFG_RST = 6'h1E;
  // timing
  localparam int CORE_PERIOD_NS = 4;
  localparam int REF_LOSS_NS = 256;
  localparam int REF_LOSS_CYC =
    (REF_LOSS_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam logic [8:0] SELFTEST_LAST = 9'h1FE;
  // phase-align buffer states
  typedef enum logic [2:0] {
    ST_RECENTER = 3'h1,
    ST_FILL = 3'h2,
    ST_RUN = 3'h4
  } pab_state_t;
endpackage

// [include/tx_mem_if.sv]
`timescale 1ns/1ns
interface tx_mem_if #(
  parameter int W = 10,
  parameter int A = 3
);
  logic wr_en;
  logic [A-1:0] wr_addr;
  logic [W-1:0] wr_data;
  logic [A-1:0] rd_addr;
  logic [W-1:0] rd_data;
  modport ctl (output wr_en, output wr_addr, output wr_data,
               output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data,
               input rd_addr, output rd_data);
endinterface

// [hw/tx_phase_mem.sv]
`timescale 1ns/1ns
module tx_phase_mem #(
  parameter int W = 10,
  parameter int A = 3
) (
  input wire logic i_wr_clk,
  input wire logic i_rd_clk,
  tx_mem_if.mem port
);
  logic [W-1:0] mem_r [0:(1<<A)-1];
  logic [W-1:0] rd_data_r;

  // write side runs on the host character clock
  always_ff @(posedge i_wr_clk) begin
    if (port.wr_en) begin
      mem_r[port.wr_addr] <= port.wr_data;
    end
  end

  // registered read on the core clock
  always_ff @(posedge i_rd_clk) begin
    rd_data_r <= mem_r[port.rd_addr];
  end

  assign port.rd_data = rd_data_r;
endmodule

// [hw/tx_char_input.sv]
`timescale 1ns/1ns
module tx_char_input
  import tx_in_pkg::*;
#(
  parameter int REF_LOSS_CYCLES = REF_LOSS_CYC
) (
  // clocks and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic I_TX_HOST_INPUT_CLOCK,
  // pins from the host
  input wire logic [CHAR_W-1:0] I_TX_CHAR_IN,
  input wire logic I_TX_REFERENCE_CLOCK,
  // configuration latches
  input wire logic I_TX_CLOCK_SOURCE_SELECT,
  input wire logic I_PHASE_BUFFER_RECENTER_N,
  input wire logic I_TX_SELFTEST_ENABLE_N,
  input wire logic I_TX_SERIAL_OUT1_ENABLE,
  input wire logic I_TX_SERIAL_OUT2_ENABLE,
  input wire logic I_TX_HALF_RATE,
  // outputs
  output logic [CHAR_W-1:0] O_TX_CHAR,
  output logic O_TX_CHAR_VALID,
  output logic O_TX_ERROR_FLAG
);
  localparam int P = BUF_ADDR_W + 1;
  localparam logic [P-1:0] HALF_FILL = P'(1 << (BUF_ADDR_W - 1));

  tx_mem_if #(.W(CHAR_W), .A(BUF_ADDR_W)) mif ();

  tx_phase_mem #(.W(CHAR_W), .A(BUF_ADDR_W)) u_mem (
    .i_wr_clk(I_TX_HOST_INPUT_CLOCK),
    .i_rd_clk(I_CORE_CLK),
    .port(mif.mem)
  );

  function automatic logic [P-1:0] gray2bin(input logic [P-1:0] g);
    logic [P-1:0] b;
    b[P-1] = g[P-1];
    for (int i = P - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // ****************************************
  // host clock domain: buffer write side
  // ****************************************
  logic rst_h_s1, rst_h_s2, rc_h_s1, rc_h_s2;
  logic [P-1:0] rdg_h_s1, rdg_h_s2;
  logic [P-1:0] wr_bin_r, wr_bin_nxt, wr_gray_r, wr_gray_nxt;
  logic ovf_tgl_r, ovf_tgl_nxt;
  logic hold_h, full_h, wr_h;
  logic [P-1:0] rd_gray_r;

  always_comb begin
    hold_h = rst_h_s2 | ~rc_h_s2;
    full_h = wr_gray_r == {~rdg_h_s2[P-1:P-2], rdg_h_s2[P-3:0]};
    wr_h = ~hold_h & ~full_h;
    wr_bin_nxt = hold_h ? '0 : wr_bin_r + P'(wr_h);
    wr_gray_nxt = wr_bin_nxt ^ (wr_bin_nxt >> 1);
    ovf_tgl_nxt = ovf_tgl_r ^ (~hold_h & full_h);
  end

  always_ff @(posedge I_TX_HOST_INPUT_CLOCK) begin
    rst_h_s1 <= I_RST;
    rst_h_s2 <= rst_h_s1;
    rc_h_s1 <= I_PHASE_BUFFER_RECENTER_N;
    rc_h_s2 <= rc_h_s1;
    rdg_h_s1 <= rd_gray_r;
    rdg_h_s2 <= rdg_h_s1;
    if (rst_h_s2) begin
      wr_bin_r <= '0;
      wr_gray_r <= '0;
      ovf_tgl_r <= 1'b0;
    end else begin
      wr_bin_r <= wr_bin_nxt;
      wr_gray_r <= wr_gray_nxt;
      ovf_tgl_r <= ovf_tgl_nxt;
    end
  end

  assign mif.wr_en = wr_h;
  assign mif.wr_addr = wr_bin_r[BUF_ADDR_W-1:0];
  assign mif.wr_data = I_TX_CHAR_IN;

  // ****************************************
  // core domain: synchronisers
  // ****************************************
  logic [CFG_W-1:0] cfg_s1, cfg_s2;
  logic [CHAR_W-1:0] dat_s1, dat_s2;
  logic ref_s1, ref_s2, ref_s3;
  logic ovf_s1, ovf_s2, ovf_s3;
  logic [P-1:0] wrg_s1, wrg_s2;

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      cfg_s1 <= CFG_RST;
      cfg_s2 <= CFG_RST;
      dat_s1 <= CHAR_RST;
      dat_s2 <= CHAR_RST;
      {ref_s1, ref_s2, ref_s3} <= 3'h0;
      {ovf_s1, ovf_s2, ovf_s3} <= 3'h0;
      wrg_s1 <= '0;
      wrg_s2 <= '0;
    end else begin
      cfg_s1 <= {I_TX_HALF_RATE, I_TX_SERIAL_OUT2_ENABLE,
                 I_TX_SERIAL_OUT1_ENABLE, I_TX_SELFTEST_ENABLE_N,
                 I_PHASE_BUFFER_RECENTER_N, I_TX_CLOCK_SOURCE_SELECT};
      cfg_s2 <= cfg_s1;
      dat_s1 <= I_TX_CHAR_IN;
      dat_s2 <= dat_s1;
      ref_s1 <= I_TX_REFERENCE_CLOCK;
      ref_s2 <= ref_s1;
      ref_s3 <= ref_s2;
      ovf_s1 <= ovf_tgl_r;
      ovf_s2 <= ovf_s1;
      ovf_s3 <= ovf_s2;
      wrg_s1 <= wr_gray_r;
      wrg_s2 <= wrg_s1;
    end
  end

  // ****************************************
  // core domain: buffer read and flag
  // ****************************************
  logic sel, recenter_n, bist, pll_down, half;
  logic strobe, underflow, overflow, set_err, absent;
  logic [P-1:0] occ;
  pab_state_t state_r, state_nxt;
  logic [P-1:0] rd_bin_r, rd_bin_nxt, rd_gray_nxt;
  logic rd_take_r, rd_take_nxt;
  logic sticky_r, sticky_nxt;
  logic [8:0] bist_cnt_r, bist_cnt_nxt;
  logic bist_pulse_r, bist_pulse_nxt;
  logic base_r, base_nxt;
  logic [15:0] loss_cnt_r, loss_cnt_nxt;
  logic flag_r, flag_nxt;
  logic [CHAR_W-1:0] char_r, char_nxt;
  logic valid_r, valid_nxt;

  always_comb begin
    // clock source chosen by the select latch
    sel = cfg_s2[CFG_SEL];
    recenter_n = cfg_s2[CFG_RECENTER_N];
    bist = ~cfg_s2[CFG_BIST_N];
    half = cfg_s2[CFG_HALF];
    // synthesizer down when both outputs off
    pll_down = ~cfg_s2[CFG_OE1] & ~cfg_s2[CFG_OE2];
    // half rate uses both reference edges
    strobe = (ref_s2 & ~ref_s3) | (half & ~ref_s2 & ref_s3);
    // reference absent after a quiet interval
    absent = loss_cnt_r == 16'(REF_LOSS_CYCLES);
    loss_cnt_nxt = (ref_s2 ^ ref_s3) ? 16'h0000
                 : (absent ? loss_cnt_r : loss_cnt_r + 16'h0001);
    occ = gray2bin(wrg_s2) - rd_bin_r;
    state_nxt = state_r;
    case (state_r)
      ST_RECENTER: begin
        if (recenter_n && !sel) begin
          state_nxt = ST_FILL;
        end
      end
      ST_FILL: begin
        if (occ >= HALF_FILL) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
      end
      default: begin
        state_nxt = ST_RECENTER;
      end
    endcase
    if (!recenter_n || sel) begin
      state_nxt = ST_RECENTER;
    end
    rd_take_nxt = (state_r == ST_RUN) & strobe & (occ != '0);
    underflow = (state_r == ST_RUN) & strobe & (occ == '0);
    overflow = (ovf_s2 ^ ovf_s3) & (state_r != ST_RECENTER);
    rd_bin_nxt = (state_r == ST_RECENTER) ? '0
               : rd_bin_r + P'(rd_take_nxt);
    rd_gray_nxt = rd_bin_nxt ^ (rd_bin_nxt >> 1);
    // buffer faults set the sticky error
    set_err = underflow | overflow;
    sticky_nxt = set_err | (sticky_r & recenter_n);
    bist_cnt_nxt = bist_cnt_r;
    bist_pulse_nxt = bist_pulse_r;
    if (!bist) begin
      bist_cnt_nxt = 9'h000;
      bist_pulse_nxt = 1'b0;
    end else if (strobe) begin
      bist_pulse_nxt = bist_cnt_r == SELFTEST_LAST;
      bist_cnt_nxt = bist_pulse_nxt ? 9'h000 : bist_cnt_r + 9'h001;
    end
    base_nxt = base_r;
    if (strobe) begin
      base_nxt = bist ? bist_pulse_nxt : sticky_nxt;
    end else if (!bist && sticky_nxt != base_r && !recenter_n) begin
      base_nxt = sticky_nxt;
    end
    // power and clock loss act at once
    flag_nxt = pll_down | absent | base_r;
    // reference path when select is one
    char_nxt = char_r;
    valid_nxt = 1'b0;
    if (sel && strobe) begin
      char_nxt = dat_s2;
      valid_nxt = 1'b1;
    end else if (rd_take_r) begin
      char_nxt = mif.rd_data;
      valid_nxt = 1'b1;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      state_r <= ST_RECENTER;
      rd_bin_r <= '0;
      rd_gray_r <= '0;
      rd_take_r <= 1'b0;
      sticky_r <= 1'b0;
      bist_cnt_r <= 9'h000;
      bist_pulse_r <= 1'b0;
      base_r <= 1'b0;
      loss_cnt_r <= 16'h0000;
      flag_r <= 1'b0;
      char_r <= CHAR_RST;
      valid_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rd_bin_r <= rd_bin_nxt;
      rd_gray_r <= rd_gray_nxt;
      rd_take_r <= rd_take_nxt;
      sticky_r <= sticky_nxt;
      bist_cnt_r <= bist_cnt_nxt;
      bist_pulse_r <= bist_pulse_nxt;
      base_r <= base_nxt;
      loss_cnt_r <= loss_cnt_nxt;
      flag_r <= flag_nxt;
      char_r <= char_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign mif.rd_addr = rd_bin_r[BUF_ADDR_W-1:0];
  assign O_TX_CHAR = char_r;
  assign O_TX_CHAR_VALID = valid_r;
  assign O_TX_ERROR_FLAG = flag_r;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);

  sequence s_ref_take;
    sel && strobe;
  endsequence
  sequence s_buf_take;
    !sel && rd_take_r;
  endsequence

  a_ref_capture: assert property (
    s_ref_take |=> O_TX_CHAR_VALID && O_TX_CHAR == $past(dat_s2))
    else $error("reference capture missed");
  a_host_capture: assert property (
    s_buf_take |=> O_TX_CHAR_VALID && O_TX_CHAR == $past(mif.rd_data))
    else $error("buffer character not presented");
  a_pll_down_flag: assert property (
    pll_down |=> O_TX_ERROR_FLAG)
    else $error("flag low with synthesizer down");
  a_ref_loss_flag: assert property (
    absent |=> O_TX_ERROR_FLAG)
    else $error("flag low with reference absent");
  a_fault_sets: assert property (
    set_err |=> sticky_r)
    else $error("buffer fault not recorded");
  a_sticky_holds: assert property (
    sticky_r && recenter_n |=> sticky_r)
    else $error("error dropped without recenter");
  a_recenter_clears: assert property (
    !recenter_n && !set_err |=> !sticky_r && state_r == ST_RECENTER)
    else $error("recenter did not clear");
  a_bist_pulse: assert property (
    bist && strobe && bist_cnt_r == SELFTEST_LAST
      |=> base_r && bist_cnt_r == 9'h000)
    else $error("self-test pulse missing");
  a_flag_timing: assert property (
    !pll_down && !absent |=> O_TX_ERROR_FLAG == $past(base_r))
    else $error("flag not from timed status");
  a_half_rate: assert property (
    sel && half && !ref_s2 && ref_s3 |=> O_TX_CHAR_VALID)
    else $error("falling edge not sampled");
endmodule

// [bench/host_model.sv]
`timescale 1ns/1ns
module host_model
  import tx_in_pkg::*;
(
  // control
  input wire logic i_run,
  // pins toward the block
  output logic o_clk,
  output logic [CHAR_W-1:0] o_char
);
  // coherent host clock
  // 80 ns like the reference, with its own phase
  initial begin
    o_clk = 1'b0;
    o_char = CHAR_RST;
    #13;
    forever begin
      #40;
      o_clk = i_run ? ~o_clk : 1'b0;
    end
  end
  // characters change away from the capture edge
  always @(negedge o_clk) o_char <= o_char + 10'h001;
endmodule

// [bench/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
  import tx_in_pkg::*;
  logic clk = 1'b0, rst = 1'b1, rclk = 1'b0, ren = 1'b1, run = 1'b1;
  logic sel = 1'b1, rec_n = 1'b1, bist_n = 1'b1, oe1 = 1'b1, oe2 = 1'b0;
  logic half = 1'b0, hclk, flag, vld;
  logic [CHAR_W-1:0] hchar, tchar = 10'h000, pins, ch, prev, cur;
  logic [CHAR_W-1:0] pat [4] = '{10'h3FF, 10'h000, 10'h2AA, 10'h155};
  int err_total = 0, checked = 0, rcnt = 0, ph = 0, n, k, r0;
  always #2 clk = ~clk;
  assign pins = run ? hchar : tchar;
  // reference clock, 80 ns, stops when disabled
  always @(negedge clk) if (ren) begin
    ph <= (ph == 9) ? 0 : ph + 1;
    if (ph == 9) rclk <= ~rclk;
    if (ph == 9 && !rclk) rcnt <= rcnt + 1;
  end
  host_model hm (.i_run(run), .o_clk(hclk), .o_char(hchar));
  tx_char_input #(.REF_LOSS_CYCLES(16)) uut (
    .I_CORE_CLK(clk), .I_RST(rst), .I_TX_HOST_INPUT_CLOCK(hclk),
    .I_TX_CHAR_IN(pins), .I_TX_REFERENCE_CLOCK(rclk),
    .I_TX_CLOCK_SOURCE_SELECT(sel), .I_PHASE_BUFFER_RECENTER_N(rec_n),
    .I_TX_SELFTEST_ENABLE_N(bist_n), .I_TX_SERIAL_OUT1_ENABLE(oe1),
    .I_TX_SERIAL_OUT2_ENABLE(oe2), .I_TX_HALF_RATE(half),
    .O_TX_CHAR(ch), .O_TX_CHAR_VALID(vld), .O_TX_ERROR_FLAG(flag));
  // ****************************
  // compare and wait tasks
  // ****************************
  task automatic close_out;
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic fail(input string m);
    err_total++;
    $display("CHECK FAILED t=%0t %s", $time, m);
  endtask
  task automatic chk(input logic [CHAR_W-1:0] got, exp, input string m);
    checked++;
    if (got !== exp) fail(m);
  endtask
  task automatic chkn(input int got, exp, input string m);
    checked++;
    if (got != exp) fail(m);
  endtask
  task automatic wflag(input logic v, input int lim);
    n = 0;
    while (flag !== v && n <= lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    checked++;
    if (n > lim) begin
      fail("error flag wait");
      close_out;
    end
  endtask
  task automatic wvld(output logic [CHAR_W-1:0] c);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (vld !== 1'b1 && n < 400);
    if (n >= 400) begin
      fail("valid wait");
      close_out;
    end
    c = ch;
  endtask
  // ****************************
  // scenarios
  // ****************************
  task automatic t_ref;
    for (int i = 0; i < 4; i++) begin
      wvld(prev);
      @(negedge clk) tchar = pat[i];
      wvld(prev);
      chk(prev, pat[i], "reference path char");
    end
    @(negedge clk) half = 1'b1;
    repeat (3) wvld(prev);
    k = 0;
    repeat (200) begin
      @(posedge clk);
      #1;
      if (vld === 1'b1) k++;
    end
    chkn(k >= 19, 1, "half rate strobes");
    @(negedge clk) half = 1'b0;
    $display("test ref done");
  endtask
  task automatic t_flag;
    @(negedge clk) oe1 = 1'b0;
    wflag(1'b1, 30);
    @(negedge clk) oe2 = 1'b1;
    wflag(1'b0, 30);
    @(negedge clk) ren = 1'b0;
    wflag(1'b1, 60);
    @(negedge clk) ren = 1'b1;
    wflag(1'b0, 100);
    $display("test flag done");
  endtask
  task automatic t_bist;
    @(negedge clk) bist_n = 1'b0;
    wflag(1'b1, 11000);
    r0 = rcnt;
    k = 0;
    while (flag === 1'b1 && k < 100) begin
      @(posedge clk);
      #1;
      k++;
    end
    chkn(k, 20, "self-test pulse width");
    wflag(1'b1, 11000);
    chkn(rcnt - r0, 511, "self-test period");
    @(negedge clk) bist_n = 1'b1;
    wflag(1'b0, 40);
    $display("test bist done");
  endtask
  task automatic t_host;
    @(negedge clk) rec_n = 1'b0;
    run = 1'b1;
    sel = 1'b0;
    repeat (100) @(negedge clk);
    rec_n = 1'b1;
    wvld(prev);
    repeat (6) begin
      wvld(cur);
      chk(cur, prev + 10'h001, "host path order");
      prev = cur;
    end
    chk(flag, 1'b0, "flag low after recenter");
    @(negedge clk) run = 1'b0;
    wflag(1'b1, 300);
    @(negedge clk) run = 1'b1;
    repeat (200) @(negedge clk);
    chk(flag, 1'b1, "flag sticky");
    rec_n = 1'b0;
    wflag(1'b0, 40);
    // hold recenter over several host edges
    repeat (100) @(negedge clk);
    rec_n = 1'b1;
    repeat (3) wvld(prev);
    // stalled reference lets the host overrun the buffer
    @(negedge clk) ren = 1'b0;
    repeat (300) @(negedge clk);
    ren = 1'b1;
    repeat (100) @(negedge clk);
    chk(flag, 1'b1, "overflow sticky");
    rec_n = 1'b0;
    wflag(1'b0, 40);
    repeat (100) @(negedge clk);
    rec_n = 1'b1;
    $display("test host done");
  endtask
  initial begin
    repeat (64) @(negedge clk);
    rst = 1'b0;
    run = 1'b0;
    @(posedge clk);
    #1;
    chk(flag, 1'b0, "flag after reset");
    t_ref();
    t_flag();
    t_bist();
    t_host();
    close_out();
  end
endmodule
